// File: pin_mux_params.svh
// Strap reset values and encodings, clock divider counts and host data bus widths for the pin multiplexer
`ifndef PIN_MUX_PARAMS_SVH
`define PIN_MUX_PARAMS_SVH

// ----------------------------------------------------------------
// Clock dividers
// ----------------------------------------------------------------
`define DIV6_RATIO 6
`define DIV4_RATIO 4

// ----------------------------------------------------------------
// Strap defaults and encodings
// ----------------------------------------------------------------
`define STRAP_AUTOINIT_OFF 1'b0
`define STRAP_FREQ_66 1'b0
`define STRAP_FREQ_33 1'b1
`define STRAP_PCI_OFF 1'b0
`define STRAP_ETH_OFF 1'b0
`define STRAP_HPI32 1'b1

// ----------------------------------------------------------------
// Host data bus
// ----------------------------------------------------------------
`define HOST_DATA_W 32
`define HOST_HALF_W 16

`endif

// File: pin_mux_pkg.sv
// Types shared by the pin multiplexer
package pin_mux_pkg;

  // ----------------------------------------------------------------
  // Latched strap configuration
  // ----------------------------------------------------------------
  typedef struct packed {
    logic autoinit_en;
    logic pci_freq_33;
    logic pci_en;
    logic eth_en;
    logic host_32bit;
  } strap_cfg_s;

  // ----------------------------------------------------------------
  // Function selected on the shared host pins
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FUNC_HOST_PORT,
    FUNC_HOST_ETH,
    FUNC_PCI
  } pin_func_e;

  // ----------------------------------------------------------------
  // Software selections for the shared general pins
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    GP0_INPUT,
    GP0_OUTPUT,
    GP0_IRQ_OUT
  } gp0_mode_e;

  typedef struct packed {
    gp0_mode_e gp0_mode;
    logic pin8_gpio;
    logic pin2_gpio;
    logic pin1_gpio;
  } pin_sel_s;

  // ----------------------------------------------------------------
  // One two-signal pad
  // ----------------------------------------------------------------
  typedef struct packed {
    logic o;
    logic oe;
  } pad_drive_s;

endpackage : pin_mux_pkg

// File: clock_divider.sv
// Square-wave clock divider with a one-cycle enable at each rising edge
module clock_divider #(
  parameter int RATIO = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Divided output
  output logic clk_div,
  output logic tick
);

  localparam int CW = (RATIO > 2) ? $clog2(RATIO) : 1;
  localparam logic [CW-1:0] LAST = CW'(RATIO - 1);
  localparam logic [CW-1:0] HALF = CW'(RATIO / 2);

  logic [CW-1:0] count_reg;

  // Ratio check
  if (RATIO < 2 || (RATIO % 2) != 0) begin : g_ratio_check
    $error("clock_divider needs an even ratio of at least 2");
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= '0;
    end else if (count_reg == LAST) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Output wave and tick
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_div <= 1'b0;
      tick <= 1'b0;
    end else begin
      clk_div <= (count_reg < HALF);
      tick <= (count_reg == '0);
    end
  end

endmodule : clock_divider

// File: pin_mux.sv
// Strap capture and shared pin function selection
// Operation
// RULE1 - Sample EEPROM auto-init strap at reset; low disabled, high enabled.
// RULE2 - General pin zero resets as input; software may make it output or interrupt.
// RULE3 - Outside logic holds general pin zero low throughout reset.
// RULE4 - Shared pin drives converter output by default; software may make it GPIO 8.
// RULE5 - With PCI enabled, frequency strap low means 66 MHz, high 33 MHz.
// RULE6 - Slowest grade board pulls frequency strap high when PCI enabled.
// RULE7 - With PCI disabled, outside logic must not pull frequency strap high.
// RULE8 - Shared pin outputs clock at one sixth rate; software may make it GPIO 2.
// RULE9 - Shared pin outputs clock at one quarter rate; software may make it GPIO 1.
// RULE10 - PCI and Ethernet straps together choose host port, Ethernet or PCI functions.
// RULE11 - Shared pin carries host interrupt by default, PCI frame when PCI selected.
// RULE12 - Host drives two register select inputs choosing control, address or data.
// RULE13 - In 16-bit mode host marks first or second half-word.
// RULE14 - Host drives read/write, address strobe, chip select, data strobes.
// RULE15 - Unused host control inputs should be pulled high externally.
// RULE16 - In 16-bit mode only lower sixteen data pins used, upper ones released.
// RULE17 - Straps latched at reset release and held until next reset.
`include "pin_mux_params.svh"

module pin_mux (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Strap pins
  input wire logic eeprom_autoinit_strap,
  input wire logic pci_freq_strap,
  input wire logic pci_enable_strap,
  input wire logic ethernet_select_strap,
  input wire logic host_width_strap,
  // Software selections
  input wire pin_mux_pkg::pin_sel_s pin_sel,
  input wire logic [2:0] gpio_out_value,
  input wire logic [2:0] gpio_out_enable,
  input wire logic gp0_out_value,
  input wire logic gpio_interrupt_out,
  // Internal sources
  input wire logic single_bit_converter_out,
  input wire logic host_interrupt_out,
  input wire logic pci_frame_out,
  input wire logic pci_frame_oe,
  input wire logic [31:0] host_data_out,
  input wire logic host_data_drive,
  // Host control pins
  input wire logic host_reg_select_hi,
  input wire logic host_reg_select_lo,
  input wire logic host_halfword_select,
  input wire logic host_read_write,
  input wire logic host_address_strobe,
  input wire logic host_chip_select_b,
  input wire logic host_data_strobe_a,
  input wire logic host_data_strobe_b,
  // General pin pads
  input wire logic gp0_pin_i,
  input wire logic pin8_i,
  input wire logic pin2_i,
  input wire logic pin1_i,
  output logic gp0_pin_o,
  output logic gp0_pin_oe,
  output logic pin8_o,
  output logic pin8_oe,
  output logic pin2_o,
  output logic pin2_oe,
  output logic pin1_o,
  output logic pin1_oe,
  // Host interrupt or frame pad
  input wire logic host_interrupt_out_pin_i,
  output logic host_interrupt_out_pin_o,
  output logic host_interrupt_out_pin_oe,
  // Host data pads
  output logic [31:0] host_data_o,
  output logic [31:0] host_data_oe,
  // Status towards the core
  output pin_mux_pkg::strap_cfg_s strap_cfg,
  output pin_mux_pkg::pin_func_e pin_func,
  output logic host_port_16bit_mode,
  output logic [3:0] general_pin_bank,
  output logic [1:0] host_reg_sel,
  output logic host_second_half,
  output logic [4:0] host_strobes,
  output logic pci_frame_in
);

  import pin_mux_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 18;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [NSYNC-1:0] pins_raw;

  assign pins_raw = {eeprom_autoinit_strap, pci_freq_strap, pci_enable_strap,
                     ethernet_select_strap, host_width_strap,
                     host_reg_select_hi, host_reg_select_lo, host_halfword_select,
                     host_read_write, host_address_strobe, host_chip_select_b,
                     host_data_strobe_a, host_data_strobe_b,
                     gp0_pin_i, pin8_i, pin2_i, pin1_i, host_interrupt_out_pin_i};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  logic [1:0] settle_reg;
  logic captured_reg;
  strap_cfg_s cfg_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_reg <= '0;
    end else if (settle_reg != 2'h3) begin
      settle_reg <= settle_reg + 2'h1;
    end
  end

  // RULE17 latch once
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      captured_reg <= 1'b0;
      cfg_reg <= '{autoinit_en: `STRAP_AUTOINIT_OFF, pci_freq_33: `STRAP_FREQ_66,
                   pci_en: `STRAP_PCI_OFF, eth_en: `STRAP_ETH_OFF,
                   host_32bit: `STRAP_HPI32};
    end else if (!captured_reg && settle_reg == 2'h2) begin
      captured_reg <= 1'b1;
      // RULE1 autoinit strap
      cfg_reg.autoinit_en <= sync2_reg[17];
      // RULE5 frequency only with PCI
      cfg_reg.pci_freq_33 <= sync2_reg[15] ? sync2_reg[16] : `STRAP_FREQ_66;
      cfg_reg.pci_en <= sync2_reg[15];
      cfg_reg.eth_en <= sync2_reg[14];
      cfg_reg.host_32bit <= sync2_reg[13];
    end
  end

  // ----------------------------------------------------------------
  // Function selection
  // ----------------------------------------------------------------
  function automatic pin_func_e decode_func(input strap_cfg_s c);
    if (c.pci_en) begin
      decode_func = FUNC_PCI;
    end else if (c.eth_en) begin
      decode_func = FUNC_HOST_ETH;
    end else begin
      decode_func = FUNC_HOST_PORT;
    end
  endfunction : decode_func

  pin_func_e func_next;
  logic is_pci;
  logic hp16;

  // RULE10 strap decode
  assign func_next = decode_func(cfg_reg);
  assign is_pci = (func_next == FUNC_PCI);
  assign hp16 = !is_pci && !cfg_reg.host_32bit;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_cfg <= '0;
      pin_func <= FUNC_HOST_PORT;
      host_port_16bit_mode <= 1'b0;
    end else begin
      strap_cfg <= cfg_reg;
      pin_func <= func_next;
      host_port_16bit_mode <= hp16;
    end
  end

  // ----------------------------------------------------------------
  // Clock outputs
  // ----------------------------------------------------------------
  logic clk6;
  logic clk4;

  clock_divider #(.RATIO(`DIV6_RATIO)) u_div6 (
    .clk(clk),
    .rst_b(rst_b),
    .clk_div(clk6),
    .tick()
  );

  clock_divider #(.RATIO(`DIV4_RATIO)) u_div4 (
    .clk(clk),
    .rst_b(rst_b),
    .clk_div(clk4),
    .tick()
  );

  // ----------------------------------------------------------------
  // General pin drivers
  // ----------------------------------------------------------------
  // RULE2 pin zero modes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gp0_pin_o <= 1'b0;
      gp0_pin_oe <= 1'b0;
    end else begin
      case (pin_sel.gp0_mode)
        GP0_OUTPUT: begin
          gp0_pin_o <= gp0_out_value;
          gp0_pin_oe <= 1'b1;
        end
        GP0_IRQ_OUT: begin
          gp0_pin_o <= gpio_interrupt_out;
          gp0_pin_oe <= 1'b1;
        end
        default: begin
          gp0_pin_o <= 1'b0;
          gp0_pin_oe <= 1'b0;
        end
      endcase
    end
  end

  // RULE4 converter or GPIO 8
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin8_o <= 1'b0;
      pin8_oe <= 1'b1;
    end else begin
      pin8_o <= pin_sel.pin8_gpio ? gpio_out_value[2] : single_bit_converter_out;
      pin8_oe <= pin_sel.pin8_gpio ? gpio_out_enable[2] : 1'b1;
    end
  end

  // RULE8 sixth clock or GPIO 2
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin2_o <= 1'b0;
      pin2_oe <= 1'b1;
    end else begin
      pin2_o <= pin_sel.pin2_gpio ? gpio_out_value[1] : clk6;
      pin2_oe <= pin_sel.pin2_gpio ? gpio_out_enable[1] : 1'b1;
    end
  end

  // RULE9 quarter clock or GPIO 1
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin1_o <= 1'b0;
      pin1_oe <= 1'b1;
    end else begin
      pin1_o <= pin_sel.pin1_gpio ? gpio_out_value[0] : clk4;
      pin1_oe <= pin_sel.pin1_gpio ? gpio_out_enable[0] : 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      general_pin_bank <= '0;
    end else begin
      general_pin_bank <= {sync2_reg[4:1]};
    end
  end

  // ----------------------------------------------------------------
  // Host interrupt or frame
  // ----------------------------------------------------------------
  // RULE11 interrupt or frame
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      host_interrupt_out_pin_o <= 1'b0;
      host_interrupt_out_pin_oe <= 1'b1;
      pci_frame_in <= 1'b1;
    end else begin
      host_interrupt_out_pin_o <= is_pci ? pci_frame_out : host_interrupt_out;
      host_interrupt_out_pin_oe <= is_pci ? pci_frame_oe : 1'b1;
      pci_frame_in <= is_pci ? sync2_reg[0] : 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Host control inputs
  // ----------------------------------------------------------------
  // RULE14 host controls only in host mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      host_reg_sel <= '0;
      host_second_half <= 1'b0;
      host_strobes <= 5'h1F;
    end else if (is_pci) begin
      host_reg_sel <= '0;
      host_second_half <= 1'b0;
      host_strobes <= 5'h1F;
    end else begin
      // RULE12 register select
      host_reg_sel <= sync2_reg[12:11];
      // RULE13 half-word marker
      host_second_half <= hp16 ? sync2_reg[10] : 1'b0;
      host_strobes <= sync2_reg[9:5];
    end
  end

  // ----------------------------------------------------------------
  // Host data drive
  // ----------------------------------------------------------------
  // RULE16 upper half released in 16-bit mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      host_data_o <= '0;
      host_data_oe <= '0;
    end else begin
      host_data_o <= host_data_out;
      host_data_oe[`HOST_HALF_W-1:0] <= {`HOST_HALF_W{host_data_drive && !is_pci}};
      host_data_oe[`HOST_DATA_W-1:`HOST_HALF_W] <=
          {(`HOST_DATA_W - `HOST_HALF_W){host_data_drive && !is_pci && !hp16}};
    end
  end

endmodule : pin_mux

// File: pin_mux_asserts.sv
// Port checks for the pin multiplexer
module pin_mux_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Selections and sources
  input wire pin_mux_pkg::pin_sel_s pin_sel,
  input wire logic gpio_interrupt_out,
  input wire logic single_bit_converter_out,
  input wire logic host_interrupt_out,
  input wire logic host_reg_select_hi,
  input wire logic host_reg_select_lo,
  input wire logic host_halfword_select,
  // Pads
  input wire logic gp0_pin_o,
  input wire logic gp0_pin_oe,
  input wire logic pin8_o,
  input wire logic pin8_oe,
  input wire logic pin2_o,
  input wire logic pin1_o,
  input wire logic host_interrupt_out_pin_o,
  input wire logic host_interrupt_out_pin_oe,
  input wire logic [31:0] host_data_oe,
  // Status
  input wire pin_mux_pkg::strap_cfg_s strap_cfg,
  input wire pin_mux_pkg::pin_func_e pin_func,
  input wire logic host_port_16bit_mode,
  input wire logic [1:0] host_reg_sel,
  input wire logic host_second_half,
  input wire logic [4:0] host_strobes
);
  timeunit 1ns;
  timeprecision 1ps;
  import pin_mux_pkg::*;
  logic [3:0] cyc, run1, run2;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // Cycles since reset and since default clock selection
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc <= 4'h0;
      run1 <= 4'h0;
      run2 <= 4'h0;
    end else begin
      cyc <= (cyc == 4'hF) ? cyc : cyc + 4'h1;
      run1 <= pin_sel.pin1_gpio ? 4'h0 : (run1 == 4'hF) ? run1 : run1 + 4'h1;
      run2 <= pin_sel.pin2_gpio ? 4'h0 : (run2 == 4'hF) ? run2 : run2 + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // pin zero modes
  a_gp0_input_only: assert property (cyc >= 4'h2 && $past(pin_sel.gp0_mode) == GP0_INPUT
    |-> !gp0_pin_oe) else $error("pin zero driven in input mode");
  a_gp0_irq_drive: assert property (cyc >= 4'h2 && $past(pin_sel.gp0_mode) == GP0_IRQ_OUT
    |-> gp0_pin_oe && gp0_pin_o == $past(gpio_interrupt_out)) else $error("pin zero irq wrong");
  a_converter_default: assert property (cyc >= 4'h2 && !$past(pin_sel.pin8_gpio)
    |-> pin8_oe && pin8_o == $past(single_bit_converter_out)) else $error("pin8 default wrong");
  a_div4_period: assert property (run1 >= 4'h6 && $rose(pin1_o)
    |-> !$past(pin1_o, 2) && $past(pin1_o, 3) && $past(pin1_o, 4)) else $error("pin1 period");
  a_div6_period: assert property (run2 >= 4'h8 && $rose(pin2_o)
    |-> !$past(pin2_o, 3) && $past(pin2_o, 4) && $past(pin2_o, 6)) else $error("pin2 period");
  a_strap_frozen: assert property (cyc >= 4'h5 |-> $stable(strap_cfg))
    else $error("strap config changed");
  a_freq_forced: assert property (cyc >= 4'h5 && !strap_cfg.pci_en
    |-> !strap_cfg.pci_freq_33) else $error("33 MHz without pci");
  a_func_decode: assert property (cyc >= 4'h6 |-> pin_func ==
    (strap_cfg.pci_en ? FUNC_PCI : strap_cfg.eth_en ? FUNC_HOST_ETH : FUNC_HOST_PORT))
    else $error("pin function wrong");
  a_host_interrupt_out_source: assert property (cyc >= 4'h6 && pin_func != FUNC_PCI
    && $past(pin_func) != FUNC_PCI |-> host_interrupt_out_pin_oe && host_interrupt_out_pin_o == $past(host_interrupt_out))
    else $error("host_interrupt_out pad wrong");
  a_host_mirror: assert property (cyc >= 4'h8 && pin_func != FUNC_PCI
    |-> host_reg_sel == {$past(host_reg_select_hi, 3), $past(host_reg_select_lo, 3)})
    else $error("register select wrong");
  a_pci_idle: assert property (cyc >= 4'h8 && pin_func == FUNC_PCI
    |-> host_strobes == 5'h1F && host_reg_sel == 2'h0) else $error("host controls not idle");
  a_halfword_sel: assert property (cyc >= 4'h8
    |-> host_second_half == (host_port_16bit_mode && $past(host_halfword_select, 3)))
    else $error("half-word select wrong");
  a_upper_hiz: assert property (host_port_16bit_mode |-> host_data_oe[31:16] == 16'h0)
    else $error("upper data driven");

  c_pci: cover property (pin_func == FUNC_PCI);
  c_eth: cover property (pin_func == FUNC_HOST_ETH);
  c_half: cover property (host_port_16bit_mode && host_second_half);
endmodule : pin_mux_asserts

bind pin_mux pin_mux_asserts u_pin_mux_asserts (
  .clk, .rst_b, .pin_sel, .gpio_interrupt_out, .single_bit_converter_out, .host_interrupt_out,
  .host_reg_select_hi, .host_reg_select_lo, .host_halfword_select, .gp0_pin_o, .gp0_pin_oe,
  .pin8_o, .pin8_oe, .pin2_o, .pin1_o, .host_interrupt_out_pin_o, .host_interrupt_out_pin_oe, .host_data_oe, .strap_cfg,
  .pin_func, .host_port_16bit_mode, .host_reg_sel, .host_second_half, .host_strobes
);

// File: host_agent.sv
// Behavioural host processor on the host control pins
module host_agent (
  // Clock
  input wire logic clk,
  // Requests from the bench
  input wire logic host_act,
  input wire logic [7:0] host_req,
  // Host pins
  output logic [7:0] host_pins,
  output logic frame_b
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clk) begin
    host_pins <= #1 host_act ? host_req : 8'hFF;
    frame_b <= #1 host_act ? ^host_req : 1'b1;
  end
endmodule : host_agent

// File: boot_strap_and_host_pin_mux_test.sv
// Self-checking bench for the pin multiplexer
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module boot_strap_and_host_pin_mux_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pin_mux_pkg::*;
  logic clk = 1'b0;
  logic rst_b, p1, p2, pf, host_act, frame_b;
  logic eeprom_autoinit_strap, pci_freq_strap, pci_enable_strap, ethernet_select_strap;
  logic host_width_strap, gp0_out_value, gpio_interrupt_out, single_bit_converter_out;
  logic host_interrupt_out, pci_frame_out, pci_frame_oe, host_data_drive;
  logic host_reg_select_hi, host_reg_select_lo, host_halfword_select, host_read_write;
  logic host_address_strobe, host_chip_select_b, host_data_strobe_a, host_data_strobe_b;
  logic gp0_pin_i, pin8_i, pin2_i, pin1_i, host_interrupt_out_pin_i, host_interrupt_out_pin_o, host_interrupt_out_pin_oe;
  logic gp0_pin_o, gp0_pin_oe, pin8_o, pin8_oe, pin2_o, pin2_oe, pin1_o, pin1_oe;
  logic host_port_16bit_mode, host_second_half, pci_frame_in;
  logic [2:0] gpio_out_value, gpio_out_enable;
  logic [31:0] host_data_out, host_data_o, host_data_oe;
  logic [3:0] general_pin_bank, ext_pads;
  logic [1:0] host_reg_sel;
  logic [4:0] host_strobes, s;
  logic [7:0] host_req, host_pins;
  pin_sel_s pin_sel;
  strap_cfg_s strap_cfg;
  pin_func_e pin_func;
  int fail_count, compares, cycles, r1, r2;

  // ----------------------------------------------------------------
  // Pads, host and design
  // ----------------------------------------------------------------
  assign {host_reg_select_hi, host_reg_select_lo, host_halfword_select, host_read_write,
    host_address_strobe, host_chip_select_b, host_data_strobe_a, host_data_strobe_b} = host_pins;
  assign gp0_pin_i = gp0_pin_oe ? gp0_pin_o : (ext_pads[3] & rst_b);
  assign pin8_i = pin8_oe ? pin8_o : ext_pads[2];
  assign pin2_i = pin2_oe ? pin2_o : ext_pads[1];
  assign pin1_i = pin1_oe ? pin1_o : ext_pads[0];
  assign host_interrupt_out_pin_i = host_interrupt_out_pin_oe ? host_interrupt_out_pin_o : frame_b;
  pin_mux u_pin_mux (
    .clk, .rst_b, .eeprom_autoinit_strap, .pci_freq_strap, .pci_enable_strap,
    .ethernet_select_strap, .host_width_strap, .pin_sel, .gpio_out_value, .gpio_out_enable,
    .gp0_out_value, .gpio_interrupt_out, .single_bit_converter_out, .host_interrupt_out,
    .pci_frame_out, .pci_frame_oe, .host_data_out, .host_data_drive, .host_reg_select_hi,
    .host_reg_select_lo, .host_halfword_select, .host_read_write, .host_address_strobe,
    .host_chip_select_b, .host_data_strobe_a, .host_data_strobe_b, .gp0_pin_i, .pin8_i,
    .pin2_i, .pin1_i, .gp0_pin_o, .gp0_pin_oe, .pin8_o, .pin8_oe, .pin2_o, .pin2_oe,
    .pin1_o, .pin1_oe, .host_interrupt_out_pin_i, .host_interrupt_out_pin_o, .host_interrupt_out_pin_oe, .host_data_o, .host_data_oe,
    .strap_cfg, .pin_func, .host_port_16bit_mode, .general_pin_bank, .host_reg_sel,
    .host_second_half, .host_strobes, .pci_frame_in
  );
  host_agent u_host_agent (.clk, .host_act, .host_req, .host_pins, .frame_b);
  always #2.5 clk = ~clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic pin_func_e exp_func(logic [4:0] st);
    return st[2] ? FUNC_PCI : st[1] ? FUNC_HOST_ETH : FUNC_HOST_PORT;
  endfunction : exp_func
  function automatic logic [31:0] exp_data_oe(logic [4:0] st, logic drv);
    return {{16{drv & st[0] & !st[2]}}, {16{drv & !st[2]}}};
  endfunction : exp_data_oe
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic rand_inputs();
    pin_sel = '{gp0_mode_e'($urandom_range(2)), 1'($urandom), 1'($urandom), 1'($urandom)};
    {gpio_out_value, gpio_out_enable, gp0_out_value, gpio_interrupt_out} = 8'($urandom);
    {single_bit_converter_out, host_interrupt_out, pci_frame_out, pci_frame_oe,
      host_data_drive} = 5'($urandom);
    host_data_out = $urandom;
    ext_pads = 4'($urandom);
    host_req = 8'($urandom);
    host_act = 1'($urandom);
  endtask : rand_inputs
  task automatic print_verdict();
    if (fail_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      fail_count++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hDF11));
    rand_inputs();
    for (int i = 0; i < 32; i++) begin
      s = 5'(i);
      if (!s[2]) s[3] = 1'b0;
      {eeprom_autoinit_strap, pci_freq_strap, pci_enable_strap, ethernet_select_strap,
        host_width_strap} = s;
      rst_b = 1'b0;
      step(10);
      `CHK("pin1_oe", 1'b1, pin1_oe)
      `CHK("gp0_pin_oe", 1'b0, gp0_pin_oe)
      rst_b = 1'b1;
      step(6);
      {eeprom_autoinit_strap, pci_enable_strap} = ~{s[4], s[2]};
      {ethernet_select_strap, host_width_strap} = ~s[1:0];
      step(4);
      `CHK("autoinit_en", s[4], strap_cfg.autoinit_en)
      `CHK("pci_freq_33", s[3] & s[2], strap_cfg.pci_freq_33)
      `CHK("pin_func", exp_func(s), pin_func)
      `CHK("host_port_16bit_mode", !s[0] && !s[2], host_port_16bit_mode)
      pin_sel = '{GP0_OUTPUT, 1'b1, 1'b1, 1'b1};
      step(1);
      `CHK("pin1", {gpio_out_value[0], gpio_out_enable[0]}, {pin1_o, pin1_oe})
      `CHK("pin2", {gpio_out_value[1], gpio_out_enable[1]}, {pin2_o, pin2_oe})
      `CHK("pin8", {gpio_out_value[2], gpio_out_enable[2]}, {pin8_o, pin8_oe})
      `CHK("gp0_pin", {gp0_out_value, 1'b1}, {gp0_pin_o, gp0_pin_oe})
      host_act = 1'b1;
      pin_sel = '{GP0_INPUT, 1'b0, 1'b0, 1'b0};
      step(5);
      `CHK("host_reg_sel", s[2] ? 2'h0 : host_req[7:6], host_reg_sel)
      `CHK("host_strobes", s[2] ? 5'h1F : host_req[4:0], host_strobes)
      `CHK("host_second_half", host_req[5] & !s[0] & !s[2], host_second_half)
      `CHK("host_interrupt_out_pin_oe", s[2] ? pci_frame_oe : 1'b1, host_interrupt_out_pin_oe)
      `CHK("pin8_o", single_bit_converter_out, pin8_o)
      `CHK("host_interrupt_out_pin_o", s[2] ? pci_frame_out : host_interrupt_out, host_interrupt_out_pin_o)
      pf = pci_frame_oe ? pci_frame_out : ^host_req;
      `CHK("pci_frame_in", s[2] ? pf : 1'b1, pci_frame_in)
      `CHK("general_pin_bank[3]", ext_pads[3], general_pin_bank[3])
      `CHK("general_pin_bank[2]", single_bit_converter_out, general_pin_bank[2])
      `CHK("host_data_o", host_data_out, host_data_o)
      `CHK("host_data_oe", exp_data_oe(s, host_data_drive), host_data_oe)
      r1 = 0;
      r2 = 0;
      p1 = pin1_o;
      p2 = pin2_o;
      repeat (12) begin
        step(1);
        r1 += int'(pin1_o && !p1);
        r2 += int'(pin2_o && !p2);
        p1 = pin1_o;
        p2 = pin2_o;
      end
      `CHK("pin1 rises", 3, r1)
      `CHK("pin2 rises", 2, r2)
      repeat (30) begin
        rand_inputs();
        step(1);
      end
    end
    print_verdict();
  end
endmodule : boot_strap_and_host_pin_mux_test
